// File: rtl/adcp_pkg.sv
// Constants and types shared by the sample output port
// Notes on behaviour
// - Outside sleep, a new conversion starts on every rising edge of the convert clock, which captures the input.
// - Each sample leaves as one 12-bit parallel word five convert-clock cycles after its capture.
// - Output-enable low (or floating) drives the word pins; high puts them in high impedance.
// - Sleep request high puts the converter into power-down; low lets it convert normally.
// - Coding select high gives two's complement words; low gives straight offset binary.
// - The valid strobe is high from one clock after a valid word loads until the word changes, and capture logic latches on it.
package adcp_pkg;

  // Word and pipeline shape
  localparam int unsigned ADCP_WORD_W      = 12;
  localparam int unsigned ADCP_LATENCY     = 5;
  localparam int unsigned ADCP_CTRL_W      = 4;

  // Bit positions inside the synchronised control group
  localparam int unsigned ADCP_CTRL_CONV   = 0;
  localparam int unsigned ADCP_CTRL_SLEEP  = 1;
  localparam int unsigned ADCP_CTRL_TWOS   = 2;
  localparam int unsigned ADCP_CTRL_OE_N   = 3;

  // Values after reset
  localparam logic [ADCP_WORD_W-1:0] ADCP_WORD_RST  = 12'h000;
  localparam logic [ADCP_CTRL_W-1:0] ADCP_CTRL_RST  = 4'hA;
  localparam logic                   ADCP_FLAG_RST  = 1'b0;
  localparam logic                   ADCP_OE_N_RST  = 1'b1;
  localparam logic [3:0]             ADCP_FILL_RST  = 4'h0;

  // Converter operating state
  typedef enum logic [1:0]
  {
    ADCP_ST_SLEEP,
    ADCP_ST_FILL,
    ADCP_ST_RUN
  } adcp_state_t;

endpackage : adcp_pkg

// File: rtl/adcp_sync2.sv
// Two-flop synchroniser for a group of level signals
`timescale 1ns/100ps
`default_nettype none

module adcp_sync2
  #(
    parameter int unsigned     W       = 1,
    parameter logic [W-1:0]    RST_VAL = '0
  )
  (
    // Clock and reset
    input  wire logic          clock_in,
    input  wire logic          rst_n_in,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [W-1:0]  async_in,
    output var  logic [W-1:0]  sync_out
  );

  logic [W-1:0] meta_q;

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : adcp_sync2

`default_nettype wire

// File: rtl/adcp_port.sv
// Sample output port: capture, latency pipeline, coding, strobe and drive control
`timescale 1ns/100ps
`default_nettype none

module adcp_port
  import adcp_pkg::*;
  #(
    parameter int unsigned WORD_W  = ADCP_WORD_W,
    parameter int unsigned LATENCY = ADCP_LATENCY
  )
  (
    // Clock and reset
    input  wire logic              clock_in,
    input  wire logic              rst_n_in,
    // Converter core side
    input  wire logic              convert_clock_in,
    input  wire logic [WORD_W-1:0] sample_code_in,
    input  wire logic              over_range_in,
    // Static control pins
    input  wire logic              output_enable_n_in,
    input  wire logic              sleep_request_in,
    input  wire logic              twos_complement_select_in,
    // Sample word pins
    output var  logic [WORD_W-1:0] sample_word_out,
    output var  logic              sample_word_oe_n_out,
    output var  logic              sample_valid_strobe_out,
    output var  logic              over_range_flag_out,
    // Status
    output var  logic              powered_down_out,
    output var  logic              pipeline_primed_out
  );

  logic [ADCP_CTRL_W-1:0] ctrl_async;
  logic [ADCP_CTRL_W-1:0] ctrl_s;
  logic [WORD_W:0]        core_async;
  logic [WORD_W:0]        core_s;
  logic                   conv_s;
  logic                   sleep_s;
  logic                   twos_s;
  logic                   oe_n_s;
  logic                   conv_prev_q;
  logic                   conv_rise;
  logic                   converting;
  adcp_state_t            state_q;
  adcp_state_t            state_d;
  logic [3:0]             fill_q;
  logic [WORD_W-1:0]      code_pipe_q [LATENCY];
  logic                   ovr_pipe_q  [LATENCY];
  logic                   vld_pipe_q  [LATENCY];
  logic                   word_valid_q;
  logic                   word_loaded_q;
  logic [WORD_W-1:0]      coded_word;

  // Control pins and core outputs cross into the clock domain
  assign ctrl_async[ADCP_CTRL_CONV]  = convert_clock_in;
  assign ctrl_async[ADCP_CTRL_SLEEP] = sleep_request_in;
  assign ctrl_async[ADCP_CTRL_TWOS]  = twos_complement_select_in;
  assign ctrl_async[ADCP_CTRL_OE_N]  = output_enable_n_in;
  assign core_async                  = {over_range_in, sample_code_in};

  adcp_sync2
    #(
      .W       (ADCP_CTRL_W),
      .RST_VAL (ADCP_CTRL_RST)
    )
    u_ctrl_sync
    (
      .clock_in (clock_in),
      .rst_n_in (rst_n_in),
      .async_in (ctrl_async),
      .sync_out (ctrl_s)
    );

  adcp_sync2
    #(
      .W       (WORD_W + 1),
      .RST_VAL ('0)
    )
    u_core_sync
    (
      .clock_in (clock_in),
      .rst_n_in (rst_n_in),
      .async_in (core_async),
      .sync_out (core_s)
    );

  assign conv_s  = ctrl_s[ADCP_CTRL_CONV];
  assign sleep_s = ctrl_s[ADCP_CTRL_SLEEP];
  assign twos_s  = ctrl_s[ADCP_CTRL_TWOS];
  assign oe_n_s  = ctrl_s[ADCP_CTRL_OE_N];

  // Convert clock rising edge detect
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      conv_prev_q <= 1'b0;
    end
    else
    begin
      conv_prev_q <= conv_s;
    end
  end

  assign conv_rise  = conv_s & ~conv_prev_q;
  assign converting = (state_q != ADCP_ST_SLEEP) && !sleep_s;

  // Operating state: sleep, pipeline filling, running
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ADCP_ST_SLEEP:
      begin
        if (!sleep_s)
        begin
          state_d = ADCP_ST_FILL;
        end
      end
      ADCP_ST_FILL:
      begin
        if (sleep_s)
        begin
          state_d = ADCP_ST_SLEEP;
        end
        else if (conv_rise && (fill_q == 4'(LATENCY)))
        begin
          state_d = ADCP_ST_RUN;
        end
      end
      ADCP_ST_RUN:
      begin
        if (sleep_s)
        begin
          state_d = ADCP_ST_SLEEP;
        end
      end
      default:
      begin
        state_d = ADCP_ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= ADCP_ST_FILL;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Counts captured samples until the first word reaches the pins
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fill_q <= ADCP_FILL_RST;
    end
    else if (state_q != ADCP_ST_FILL)
    begin
      fill_q <= ADCP_FILL_RST;
    end
    else if (conv_rise && (fill_q != 4'(LATENCY)))
    begin
      fill_q <= fill_q + 4'h1;
    end
  end

  // Latency pipeline; stage 0 is the track-and-hold capture
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < LATENCY; i++)
      begin
        code_pipe_q[i] <= ADCP_WORD_RST;
        ovr_pipe_q[i]  <= ADCP_FLAG_RST;
        vld_pipe_q[i]  <= 1'b0;
      end
    end
    else if (!converting)
    begin
      for (int i = 0; i < LATENCY; i++)
      begin
        vld_pipe_q[i] <= 1'b0;
      end
    end
    else if (conv_rise)
    begin
      code_pipe_q[0] <= core_s[WORD_W-1:0];
      ovr_pipe_q[0]  <= core_s[WORD_W];
      vld_pipe_q[0]  <= 1'b1;
      for (int i = 1; i < LATENCY; i++)
      begin
        code_pipe_q[i] <= code_pipe_q[i-1];
        ovr_pipe_q[i]  <= ovr_pipe_q[i-1];
        vld_pipe_q[i]  <= vld_pipe_q[i-1];
      end
    end
  end

  // Offset binary to two's complement is an inverted top bit
  assign coded_word = code_pipe_q[LATENCY-1]
                      ^ {twos_s, {(WORD_W-1){1'b0}}};

  // Output word register, loaded on the edge that ends the latency
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sample_word_out     <= ADCP_WORD_RST;
      over_range_flag_out <= ADCP_FLAG_RST;
      word_valid_q        <= 1'b0;
      word_loaded_q       <= 1'b0;
    end
    else if (!converting)
    begin
      word_valid_q  <= 1'b0;
      word_loaded_q <= 1'b0;
    end
    else if (conv_rise)
    begin
      sample_word_out     <= coded_word;
      over_range_flag_out <= ovr_pipe_q[LATENCY-1];
      word_valid_q        <= vld_pipe_q[LATENCY-1];
      word_loaded_q       <= 1'b1;
    end
    else
    begin
      word_loaded_q <= 1'b0;
    end
  end

  // Strobe rises once the new word is stable and falls as it changes
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sample_valid_strobe_out <= 1'b0;
    end
    else if (!converting || conv_rise)
    begin
      sample_valid_strobe_out <= 1'b0;
    end
    else if (word_loaded_q && word_valid_q)
    begin
      sample_valid_strobe_out <= 1'b1;
    end
  end

  // Word pin drive follows the synchronised output-enable pin
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sample_word_oe_n_out <= ADCP_OE_N_RST;
    end
    else
    begin
      sample_word_oe_n_out <= oe_n_s;
    end
  end

  // Status outputs
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      powered_down_out    <= 1'b0;
      pipeline_primed_out <= 1'b0;
    end
    else
    begin
      powered_down_out    <= (state_d == ADCP_ST_SLEEP);
      pipeline_primed_out <= (state_d == ADCP_ST_RUN);
    end
  end

endmodule : adcp_port

`default_nettype wire

// File: tb/adcp_capture_model.sv
// Capture logic model latching sample words on the valid strobe
`timescale 1ns/100ps
`default_nettype none
module adcp_capture_model
  import adcp_pkg::*;
  (
    // Clock
    input  wire logic                   clock_in,
    // Sample word pins
    input  wire logic [ADCP_WORD_W-1:0] word_in,
    input  wire logic                   strobe_in,
    input  wire logic                   flag_in,
    // Latched sample
    output var  logic [ADCP_WORD_W-1:0] word_out,
    output var  logic                   flag_out,
    output var  logic                   got_out
  );
  logic strobe_q;
  always_ff @(posedge clock_in)
  begin
    strobe_q <= strobe_in;
    got_out  <= strobe_in && !strobe_q;
    if (strobe_in && !strobe_q)
    begin
      word_out <= word_in;
      flag_out <= flag_in;
    end
  end
endmodule : adcp_capture_model
`default_nettype wire

// File: tb/adcp_port_properties.sv
// Concurrent checks on the sample output port
`timescale 1ns/100ps
`default_nettype none
module adcp_port_properties
  #(parameter int unsigned WORD_W = 12)
  (
    // Clock, reset and control pins
    input wire logic              clock_in,
    input wire logic              rst_n_in,
    input wire logic              output_enable_n_in,
    input wire logic              sleep_request_in,
    // Outputs
    input wire logic [WORD_W-1:0] sample_word_out,
    input wire logic              sample_word_oe_n_out,
    input wire logic              sample_valid_strobe_out,
    input wire logic              over_range_flag_out,
    input wire logic              powered_down_out,
    input wire logic              pipeline_primed_out
  );
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_drive_follows_pin: assert property ($changed(output_enable_n_in) |-> ##3
    sample_word_oe_n_out == $past(output_enable_n_in, 3)) else $error("drive late");
  a_sleep_enters_down: assert property ($rose(sleep_request_in) |-> ##[3:4]
    powered_down_out) else $error("no power down");
  a_sleep_no_strobe: assert property (powered_down_out |->
    !sample_valid_strobe_out) else $error("strobe in sleep");
  a_sleep_not_primed: assert property (powered_down_out |->
    !pipeline_primed_out) else $error("primed in sleep");
  a_load_drops_strobe: assert property ($changed(sample_word_out) |->
    !sample_valid_strobe_out) else $error("word changed under strobe");
  a_strobe_word_stable: assert property ($rose(sample_valid_strobe_out) |->
    $stable(sample_word_out) && $stable(over_range_flag_out)) else $error("word moving");
  a_strobe_when_primed: assert property (sample_valid_strobe_out |->
    pipeline_primed_out) else $error("strobe before fill");
  a_flag_with_word: assert property ($changed(over_range_flag_out) |->
    !sample_valid_strobe_out) else $error("flag changed under strobe");
endmodule : adcp_port_properties
bind adcp_port adcp_port_properties #(.WORD_W(WORD_W)) adcp_port_properties_i (.clock_in,
  .rst_n_in, .output_enable_n_in, .sleep_request_in, .sample_word_out, .sample_word_oe_n_out,
  .sample_valid_strobe_out, .over_range_flag_out, .powered_down_out, .pipeline_primed_out);
`default_nettype wire

// File: tb/testbench.sv
// Testbench for the sample output port
`timescale 1ns/100ps
`default_nettype none
module testbench
  import adcp_pkg::*;
  ;
  localparam int N = 6;
  logic        clock_in, rst_n_in, convert_clock_in, over_range_in;
  logic        output_enable_n_in, sleep_request_in, twos_complement_select_in;
  logic [11:0] sample_code_in, sample_word_out, cap_word;
  logic        sample_word_oe_n_out, sample_valid_strobe_out, over_range_flag_out;
  logic        powered_down_out, pipeline_primed_out, cap_flag, got;
  int          num_errors, checked, idx, cycles;
  // Rows: coding select, over-range, raw code, expected word on the pins
  logic [25:0] rows [N] = '{{2'b00, 12'h000, 12'h000}, {2'b01, 12'hFFF, 12'hFFF},
                            {2'b10, 12'h800, 12'h000}, {2'b10, 12'h7FF, 12'hFFF},
                            {2'b11, 12'h123, 12'h923}, {2'b00, 12'hABC, 12'hABC}};
  adcp_port adcp_port_i (.clock_in, .rst_n_in, .convert_clock_in, .sample_code_in,
    .over_range_in, .output_enable_n_in, .sleep_request_in, .twos_complement_select_in,
    .sample_word_out, .sample_word_oe_n_out, .sample_valid_strobe_out, .over_range_flag_out,
    .powered_down_out, .pipeline_primed_out);
  adcp_capture_model adcp_capture_model_i (.clock_in, .word_in(sample_word_out),
    .strobe_in(sample_valid_strobe_out), .flag_in(over_range_flag_out),
    .word_out(cap_word), .flag_out(cap_flag), .got_out(got));
  initial
  begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  task automatic cmp(string name, logic [11:0] exp, logic [11:0] seen);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : cmp
  task automatic end_sim();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // One convert period: code set while low, twos select for the word loaded at this rise
  task automatic convert(int j);
    logic [25:0] r;
    logic [25:0] p;
    r = (j < N) ? rows[j] : {2'b00, 12'h5A5, 12'h000};
    p = (j >= 5 && j < N + 5) ? rows[j-5] : 26'h0000000;
    @(posedge clock_in);
    convert_clock_in <= 1'b0;
    sample_code_in <= r[23:12];
    over_range_in <= r[24];
    twos_complement_select_in <= p[25];
    repeat (4) @(posedge clock_in);
    convert_clock_in <= 1'b1;
    repeat (3) @(posedge clock_in);
  endtask : convert
  task automatic settle(int n);
    repeat (n) @(posedge clock_in);
    @(negedge clock_in);
  endtask : settle
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      num_errors++;
      end_sim();
    end
  end
  always @(posedge clock_in)
    if (got === 1'b1)
    begin
      if (idx < N)
      begin
        cmp("word", rows[idx][11:0], cap_word);
        cmp("flag", {11'h000, rows[idx][24]}, {11'h000, cap_flag});
      end
      idx++;
    end
  initial
  begin
    rst_n_in <= 1'b0;
    convert_clock_in <= 1'b0;
    sample_code_in <= 12'h000;
    over_range_in <= 1'b0;
    output_enable_n_in <= 1'b0;
    sleep_request_in <= 1'b0;
    twos_complement_select_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    for (int j = 0; j < N + 5; j++)
      convert(j);
    settle(8);
    cmp("count", 12'(N), 12'(idx));
    cmp("primed", 12'h001, {11'h000, pipeline_primed_out});
    for (int v = 1; v >= 0; v--)
    begin
      @(posedge clock_in);
      output_enable_n_in <= v[0];
      settle(3);
      cmp("drive", {11'h000, v[0]}, {11'h000, sample_word_oe_n_out});
    end
    @(posedge clock_in);
    sleep_request_in <= 1'b1;
    convert(0);
    settle(8);
    cmp("down", 12'h001, {11'h000, powered_down_out});
    cmp("asleep count", 12'(N), 12'(idx));
    @(posedge clock_in);
    sleep_request_in <= 1'b0;
    settle(4);
    cmp("awake", 12'h000, {10'h000, powered_down_out, pipeline_primed_out});
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    @(negedge clock_in);
    cmp("reset word", 12'h000, sample_word_out);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
